// *** include/irpl_pkg.sv ***
// Contract
// - motherboard: line four driven by uart mapped to slot one or three
// - motherboard: line three driven by uart mapped to slot two or four
// - uart request gated by its enable; inactive when disabled or reset
// - adapter: one irq output per uart, carrying only its own request
// - floppy irq passes only while digital output register bit 3 is set
// - printer irq gated by control bit 4 and config register one, three
// - enhanced or ecp mode: printer irq pulses low, then releases the line
// - hardware reset clears functional state; configuration inputs untouched
// - adapter latches jumper inputs at falling reset edge, held through reset until the next falling edge
package irpl_pkg;
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned RST_MIN_NS     = 500;
  localparam int unsigned RST_MIN_CYC    =
    (RST_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned PULSE_CYC      = 2;
  localparam int unsigned FD_IRQ_EN_BIT  = 3;
  localparam int unsigned PCR_IRQ_EN_BIT = 4;
  localparam int unsigned JUMPER_W       = 4;
  localparam logic [JUMPER_W-1:0] JUMPER_RST = 4'h0;
  // serial base address slot codes
  typedef enum logic [2:0] {
    IRPL_SLOT_OFF  = 3'b000,
    IRPL_SLOT_COM1 = 3'b001,
    IRPL_SLOT_COM2 = 3'b010,
    IRPL_SLOT_COM3 = 3'b011,
    IRPL_SLOT_COM4 = 3'b100
  } irpl_slot_t;
  typedef enum logic [1:0] {
    IRPL_PP_IDLE  = 2'b00,
    IRPL_PP_PULSE = 2'b01,
    IRPL_PP_WAIT  = 2'b10
  } irpl_pp_state_t;
endpackage

// *** include/irpl_uart_if.sv ***
interface irpl_uart_if;
  import irpl_pkg::*;
  logic       req;
  logic       enable;
  irpl_slot_t slot;
  logic       gated;
  logic       to_line4;
  logic       to_line3;
  modport src (output req, output enable, output slot,
               input gated, input to_line4, input to_line3);
  modport gate (input req, input enable, input slot,
                output gated, output to_line4, output to_line3);
endinterface

// *** verilog/irpl_uart_route.sv ***
module irpl_uart_route (
  irpl_uart_if.gate u
);
  import irpl_pkg::*;
  wire slot_a = (u.slot == IRPL_SLOT_COM1) || (u.slot == IRPL_SLOT_COM3);
  wire slot_b = (u.slot == IRPL_SLOT_COM2) || (u.slot == IRPL_SLOT_COM4);
  assign u.gated    = u.req & u.enable;
  assign u.to_line4 = u.gated & slot_a;
  assign u.to_line3 = u.gated & slot_b;
endmodule

// *** verilog/irpl_top.sv ***
module irpl_top
  import irpl_pkg::*;
#(
  parameter int unsigned          PULSE_LEN = irpl_pkg::PULSE_CYC,
  parameter int unsigned          NJUMP     = irpl_pkg::JUMPER_W
) (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               adapter_mode,
  input  wire logic               first_uart_req,
  input  wire logic               first_uart_irq_enable_reg,
  input  wire irpl_pkg::irpl_slot_t first_uart_slot,
  input  wire logic               second_uart_req,
  input  wire logic               second_uart_irq_enable_reg,
  input  wire irpl_pkg::irpl_slot_t second_uart_slot,
  input  wire logic               floppy_req,
  input  wire logic [7:0]         floppy_digital_output_reg,
  input  wire logic               printer_req,
  input  wire logic [7:0]         printer_ctrl_reg,
  input  wire logic               config_reg_one_irq_ok,
  input  wire logic               config_reg_three_irq_ok,
  input  wire logic               printer_shared_mode,
  input  wire logic [NJUMP-1:0]   jumper_in,
  output logic                    irq4_out,
  output logic                    irq3_out,
  output logic                    first_uart_irq_out,
  output logic                    second_uart_irq_out,
  output logic                    floppy_irq_out,
  output logic                    printer_port_irq_out,
  output logic                    printer_port_irq_oe,
  output logic [NJUMP-1:0]        jumper_latched
);
  import irpl_pkg::*;

  // pin-side inputs: two flops each
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  wire  [5:0] raw_in = {adapter_mode, first_uart_req, second_uart_req,
                        floppy_req, printer_req, srst};
  always_ff @(posedge clk) begin
    sync1_reg <= raw_in;
    sync2_reg <= sync1_reg;
  end
  wire mode_ad  = sync2_reg[5];
  wire u1_req   = sync2_reg[4];
  wire u2_req   = sync2_reg[3];
  wire fd_req   = sync2_reg[2];
  wire pp_req   = sync2_reg[1];
  wire rst_seen = sync2_reg[0];

  logic [NJUMP-1:0] jsync1_reg;
  logic [NJUMP-1:0] jsync2_reg;
  always_ff @(posedge clk) begin
    jsync1_reg <= jumper_in;
    jsync2_reg <= jsync1_reg;
  end

  irpl_uart_if u1 ();
  irpl_uart_if u2 ();
  assign u1.req    = u1_req;
  assign u1.enable = first_uart_irq_enable_reg;
  assign u1.slot   = first_uart_slot;
  assign u2.req    = u2_req;
  assign u2.enable = second_uart_irq_enable_reg;
  assign u2.slot   = second_uart_slot;
  irpl_uart_route route1 (.u(u1));
  irpl_uart_route route2 (.u(u2));

  wire line4_next = ~mode_ad & (u1.to_line4 | u2.to_line4);
  wire line3_next = ~mode_ad & (u1.to_line3 | u2.to_line3);
  wire u1_out_next = mode_ad & u1.gated;
  wire u2_out_next = mode_ad & u2.gated;
  wire fd_next = fd_req & floppy_digital_output_reg[FD_IRQ_EN_BIT];
  wire pp_gated = pp_req & printer_ctrl_reg[PCR_IRQ_EN_BIT]
                  & config_reg_one_irq_ok & config_reg_three_irq_ok;

  // jumper latch on falling reset edge; survives reset by design
  logic rst_d_reg;
  logic [NJUMP-1:0] jumper_reg;
  wire rst_fall = rst_d_reg & ~rst_seen;
  always_ff @(posedge clk) begin
    rst_d_reg <= rst_seen;
    if (rst_fall && mode_ad) begin
      jumper_reg <= jsync2_reg;
    end
  end
  assign jumper_latched = jumper_reg;

  // shared-line pulse: low for PULSE_LEN, released until request drops
  irpl_pp_state_t pp_state_reg;
  irpl_pp_state_t pp_state_next;
  logic [7:0]     pp_cnt_reg;
  logic [7:0]     pp_cnt_next;
  wire pp_cnt_done = (pp_cnt_reg == 8'(PULSE_LEN - 1));
  always_comb begin
    pp_state_next = pp_state_reg;
    pp_cnt_next   = pp_cnt_reg;
    case (pp_state_reg)
      IRPL_PP_IDLE: begin
        pp_cnt_next = 8'h00;
        if (pp_gated && printer_shared_mode) begin
          pp_state_next = IRPL_PP_PULSE;
        end
      end
      IRPL_PP_PULSE: begin
        pp_cnt_next = pp_cnt_reg + 8'h01;
        if (pp_cnt_done) begin
          pp_state_next = IRPL_PP_WAIT;
        end
      end
      IRPL_PP_WAIT: begin
        if (!pp_gated) begin
          pp_state_next = IRPL_PP_IDLE;
        end
      end
      default: pp_state_next = IRPL_PP_IDLE;
    endcase
  end
  wire pulse_low_next = (pp_state_next == IRPL_PP_PULSE);
  wire pp_out_next = printer_shared_mode ? 1'b0 : pp_gated;
  wire pp_oe_next  = printer_shared_mode ? pulse_low_next : 1'b1;

  // outputs from flops; reset clears only functional state
  always_ff @(posedge clk) begin
    if (srst) begin
      irq4_out             <= 1'b0;
      irq3_out             <= 1'b0;
      first_uart_irq_out   <= 1'b0;
      second_uart_irq_out  <= 1'b0;
      floppy_irq_out       <= 1'b0;
      printer_port_irq_out <= 1'b0;
      printer_port_irq_oe  <= 1'b0;
      pp_state_reg         <= IRPL_PP_IDLE;
      pp_cnt_reg           <= 8'h00;
    end else begin
      irq4_out             <= line4_next;
      irq3_out             <= line3_next;
      first_uart_irq_out   <= u1_out_next;
      second_uart_irq_out  <= u2_out_next;
      floppy_irq_out       <= fd_next;
      printer_port_irq_out <= pp_out_next;
      printer_port_irq_oe  <= pp_oe_next;
      pp_state_reg         <= pp_state_next;
      pp_cnt_reg           <= pp_cnt_next;
    end
  end

  // reset history: a shift register clears its unknowns, a counter would not
  logic [RST_MIN_CYC-1:0] rst_hist_reg;
  always_ff @(posedge clk) begin
    rst_hist_reg <= {rst_hist_reg[RST_MIN_CYC-2:0], srst};
  end

  // shared pulse length helper; skips the cycle shared mode switches on
  logic       shared_d_reg;
  logic [7:0] oe_run_reg;
  wire        oe_run_inc = printer_port_irq_oe && printer_shared_mode
                           && shared_d_reg;
  always_ff @(posedge clk) begin
    shared_d_reg <= printer_shared_mode;
    if (!oe_run_inc) begin
      oe_run_reg <= 8'h00;
    end else if (oe_run_reg != 8'hff) begin
      oe_run_reg <= oe_run_reg + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  line4_route_a: assert property (
    !mode_ad && $stable(mode_ad) && u1.to_line4 |=> irq4_out)
    else $error("line four missed a mapped uart request");
  line3_route_a: assert property (
    !mode_ad && $stable(mode_ad) && u2.to_line3 |=> irq3_out)
    else $error("line three missed a mapped uart request");
  uart_gate_a: assert property (
    !first_uart_irq_enable_reg && !second_uart_irq_enable_reg |=>
      !first_uart_irq_out && !second_uart_irq_out)
    else $error("disabled uart request passed");
  adapter_sep_a: assert property (
    mode_ad |=> !irq4_out && !irq3_out)
    else $error("adapter variant drove shared lines");
  adapter_pass_a: assert property (
    mode_ad |=> (first_uart_irq_out == $past(u1.gated))
      && (second_uart_irq_out == $past(u2.gated)))
    else $error("adapter irq output lost its own request");
  floppy_gate_a: assert property (
    !floppy_digital_output_reg[FD_IRQ_EN_BIT] |=> !floppy_irq_out)
    else $error("floppy irq passed while disabled");
  floppy_pass_a: assert property (
    fd_req && floppy_digital_output_reg[FD_IRQ_EN_BIT] |=> floppy_irq_out)
    else $error("enabled floppy request did not reach its pin");
  printer_gate_a: assert property (
    !printer_ctrl_reg[PCR_IRQ_EN_BIT] && !printer_shared_mode
      |=> !printer_port_irq_out)
    else $error("printer irq passed while disabled");
  printer_pass_a: assert property (
    pp_gated && !printer_shared_mode
      |=> printer_port_irq_out && printer_port_irq_oe)
    else $error("enabled printer request did not reach its pin");
  pulse_len_a: assert property (
    $fell(printer_port_irq_oe) && printer_shared_mode
      && (oe_run_reg != 8'h00) |-> oe_run_reg == 8'(PULSE_LEN))
    else $error("shared pulse length wrong");
  pulse_low_a: assert property (
    $past(printer_shared_mode) |-> !printer_port_irq_out)
    else $error("shared printer line driven high");
  reset_clear_a: assert property (@(posedge clk) disable iff (1'b0)
    srst |=> !irq4_out && !irq3_out && !floppy_irq_out
      && !first_uart_irq_out && !second_uart_irq_out
      && !printer_port_irq_out && !printer_port_irq_oe)
    else $error("reset left an irq active");
  unmapped_a: assert property (
    (u1.slot == IRPL_SLOT_OFF) && (u2.slot == IRPL_SLOT_OFF)
      && $stable(u1.slot) && $stable(u2.slot) |=> !irq4_out && !irq3_out)
    else $error("unmapped uart drove a line");
  jumper_hold_a: assert property (@(posedge clk)
    !rst_fall |=> $stable(jumper_reg))
    else $error("jumper latch changed outside reset edge");
  reset_width_a: assert property (@(posedge clk)
    $fell(srst) |-> &rst_hist_reg)
    else $error("reset pulse too short");
  jumper_take_a: assert property (
    rst_fall && mode_ad |=> jumper_reg == $past(jsync2_reg))
    else $error("jumper latch missed the falling reset edge");

  cov_line4_c:   cover property (irq4_out);
  cov_adapter_c: cover property (first_uart_irq_out && second_uart_irq_out);
  cov_pulse_c:   cover property (pp_state_reg == IRPL_PP_WAIT);
  cov_jumper_c:  cover property (rst_fall && mode_ad);
  cov_floppy_c:  cover property (floppy_irq_out);
endmodule

// *** sim/irpl_host_model.sv ***
module irpl_host_model #(
  parameter int HOLD_CYC = 16
) (
  input  wire logic clk,
  input  wire logic go,
  output logic      srst
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = HOLD_CYC;
  initial srst = 1'b1;
  // held well past 500 ns, never a short glitch
  always @(posedge clk) begin
    if (go)
      cnt <= HOLD_CYC;
    else if (cnt > 0)
      cnt <= cnt - 1;
    srst <= go || cnt > 1;
  end
endmodule

// *** sim/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import irpl_pkg::*;
  localparam int PL = 3;
  logic clk = 1'b0, go = 1'b0, am = 1'b0, shared = 1'b0;
  logic r1 = 1'b0, e1 = 1'b0, r2 = 1'b0, e2 = 1'b0, fq = 1'b0, pq = 1'b0;
  logic c1 = 1'b0, c3 = 1'b0, srst;
  logic [7:0] fdor = 8'h00, pcr = 8'h00;
  logic [3:0] jin = 4'h0, jl;
  irpl_slot_t s1 = IRPL_SLOT_OFF, s2 = IRPL_SLOT_OFF;
  logic i4, i3, u1, u2, fo, po, poe;
  logic [8:0] expq[$];
  event smp;
  int seed = 6131, mismatches = 0, checks_done = 0, k;
  always #20 clk = ~clk;
  irpl_host_model host_u (.clk(clk), .go(go), .srst(srst));
  irpl_top #(.PULSE_LEN(PL)) dut_u (.clk(clk), .srst(srst),
    .adapter_mode(am), .first_uart_req(r1),
    .first_uart_irq_enable_reg(e1), .first_uart_slot(s1),
    .second_uart_req(r2), .second_uart_irq_enable_reg(e2),
    .second_uart_slot(s2), .floppy_req(fq), .floppy_digital_output_reg(fdor),
    .printer_req(pq), .printer_ctrl_reg(pcr), .config_reg_one_irq_ok(c1),
    .config_reg_three_irq_ok(c3), .printer_shared_mode(shared),
    .jumper_in(jin), .irq4_out(i4), .irq3_out(i3), .first_uart_irq_out(u1),
    .second_uart_irq_out(u2), .floppy_irq_out(fo), .printer_port_irq_out(po),
    .printer_port_irq_oe(poe), .jumper_latched(jl));
  function automatic logic rb();
    return 1'($random(seed));
  endfunction
  function automatic logic [6:0] expect_irq();
    logic g1, g2, h1, h2, l1, l2;
    g1 = r1 & e1;
    g2 = r2 & e2;
    h1 = s1 == IRPL_SLOT_COM1 || s1 == IRPL_SLOT_COM3;
    h2 = s2 == IRPL_SLOT_COM1 || s2 == IRPL_SLOT_COM3;
    l1 = s1 == IRPL_SLOT_COM2 || s1 == IRPL_SLOT_COM4;
    l2 = s2 == IRPL_SLOT_COM2 || s2 == IRPL_SLOT_COM4;
    return {~am & (g1 & h1 | g2 & h2), ~am & (g1 & l1 | g2 & l2), am & g1,
      am & g2, fq & fdor[FD_IRQ_EN_BIT],
      pq & pcr[PCR_IRQ_EN_BIT] & c1 & c3, 1'b1};
  endfunction
  task automatic note(input logic [8:0] n);
    expq.push_back(n);
    ->smp;
  endtask
  task automatic bad(input string m);
    mismatches++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic compare_irq(input logic [6:0] e, input logic [6:0] o);
    checks_done++;
    if (o !== e)
      bad($sformatf("irq pins %b expected %b", o, e));
  endtask
  task automatic compare_pulse(input logic [6:0] e, input logic [6:0] o);
    checks_done++;
    if (o !== e)
      bad($sformatf("low pulse %0d cycles expected %0d", o, e));
  endtask
  task automatic compare_jump(input logic [3:0] e, input logic [3:0] o);
    checks_done++;
    if (o !== e)
      bad($sformatf("jumpers %h expected %h", o, e));
  endtask
  task automatic finish_test();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(smp) begin : mon
    logic [8:0] n;
    logic [6:0] o;
    int c;
    n = expq.pop_front();
    o = {i4, i3, u1, u2, fo, po, poe};
    case (n[8:7])
      2'd0: compare_irq(n[6:0], o);
      2'd1: begin
        c = 0;
        repeat (10) begin
          @(posedge clk);
          #1;
          if (poe === 1'b1 && po === 1'b0)
            c++;
        end
        compare_pulse(n[6:0], 7'(c));
      end
      default: compare_jump(n[3:0], jl);
    endcase
  end
  initial begin
    #200000;
    bad("watchdog expired");
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    repeat (60) begin
      @(posedge clk);
      am <= rb();
      r1 <= rb();
      e1 <= rb();
      r2 <= rb();
      e2 <= rb();
      s1 <= irpl_slot_t'(3'({$random(seed)} % 5));
      s2 <= irpl_slot_t'(3'({$random(seed)} % 5));
      fq <= rb();
      pq <= rb();
      c1 <= rb();
      c3 <= rb();
      fdor <= 8'($random(seed));
      pcr <= 8'($random(seed));
      repeat (4) @(posedge clk);
      #1 note({2'd0, expect_irq()});
    end
    @(posedge clk);
    shared <= 1'b1;
    pq <= 1'b0;
    c1 <= 1'b1;
    c3 <= 1'b1;
    pcr <= 8'h10;
    repeat (5) @(posedge clk);
    pq <= 1'b1;
    note({2'd1, 7'(PL)});
    repeat (12) @(posedge clk);
    am <= 1'b1;
    r1 <= 1'b1;
    e1 <= 1'b1;
    shared <= 1'b0;
    jin <= 4'h5;
    repeat (4) @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    #1 note({2'd0, 7'h00});
    k = 0;
    while (srst !== 1'b0 && k < 40) begin
      @(posedge clk);
      k++;
    end
    repeat (6) @(posedge clk);
    #1 note({5'h10, 4'h5});
    jin <= 4'ha;
    repeat (6) @(posedge clk);
    #1 note({5'h10, 4'h5});
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule
